// ===== dsrc_regs.sv
// Function
// RULE1 - hold low byte of 10-bit sync delay in pixel clocks
// RULE2 - configured sync delay sets crossing FIFO depth output
// RULE3 - software keeps delay at or below 766; low byte resets 0x20
// RULE4 - high-speed receiver override bit 6, clock lane bit 4, data lanes 3:0
// RULE5 - low-power receiver override bit 6, clock lane bit 4, data lanes 3:0
// RULE6 - termination override bit 6, clock lane bit 4, data lanes 3:0
// RULE7 - divider override bit 7 selects programmed M and N
// RULE8 - automatic M from lane count, bytes per pixel, single or dual mode
// RULE9 - override clear: M field reads automatic value
// RULE10 - override set: written M drives divider
// RULE11 - bits 9:8 of delay held in companion high register
// RULE12 - 8-bit N field, automatic on read unless override set
// RULE13 - override clear: lane enables come from internal lane state
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "dsrc_map.svh"
module dsrc_regs
	import dsrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] lane_count,
	input wire logic [1:0] bytes_per_pixel,
	input wire logic dual_mode,
	input wire logic [7:0] auto_div_n,
	input wire logic [4:0] lane_state_hs,
	input wire logic [4:0] lane_state_lp,
	input wire logic [4:0] lane_state_term,
	output logic [9:0] sync_fifo_depth,
	output logic [4:0] hs_rx_en,
	output logic [4:0] lp_rx_en,
	output logic [4:0] rx_term_en,
	output logic div_override,
	output dsrc_div_t div_setting
);
	logic [7:0] sync_lo_r;
	logic [1:0] sync_hi_r;
	logic [7:0] hsrx_r;
	logic [7:0] lprx_r;
	logic [7:0] term_r;
	logic div_ov_r;
	logic [4:0] div_m_r;
	logic [7:0] div_n_r;
	logic [4:0] auto_m_r;
	dsrc_state_t state_r;
	dsrc_state_t state_nxt;

	function automatic logic [4:0] lane_sel(input logic [7:0] reg_v, input logic [4:0] internal);
		lane_sel = reg_v[`DSRC_BIT_OV] ? {reg_v[`DSRC_BIT_CLK], reg_v[3:0]} : internal;
	endfunction

	wire [9:0] byte_idx = paddr[11:2];
	wire addr_ok = (paddr[1:0] == 2'h0) && (byte_idx[9:8] == 2'h0);
	wire [7:0] idx = byte_idx[7:0];
	wire hit_hi = addr_ok && idx == `DSRC_IDX_SYNC_HI;
	wire hit_lo = addr_ok && idx == `DSRC_IDX_SYNC_LO;
	wire hit_hs = addr_ok && idx == `DSRC_IDX_HSRX;
	wire hit_lp = addr_ok && idx == `DSRC_IDX_LPRX;
	wire hit_tm = addr_ok && idx == `DSRC_IDX_TERM;
	wire hit_m = addr_ok && idx == `DSRC_IDX_DIV_M;
	wire hit_n = addr_ok && idx == `DSRC_IDX_DIV_N;
	wire mapped = hit_hi | hit_lo | hit_hs | hit_lp | hit_tm | hit_m | hit_n;
	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite && mapped && state_r == DSRC_ACCESS;

	// automatic M: lanes times (bytes-per-pixel plus one), doubled in dual mode
	wire [4:0] auto_m = 5'((6'(lane_count) * (6'(bytes_per_pixel) + 6'h01)) << dual_mode); // RULE8

	wire [7:0] rd_m = {div_ov_r, 2'h0, div_ov_r ? div_m_r : auto_m_r}; // RULE9
	wire [7:0] rd_n = div_ov_r ? div_n_r : auto_div_n; // RULE12
	wire [7:0] rd_val = hit_hi ? {6'h00, sync_hi_r} :
		hit_lo ? sync_lo_r :
		hit_hs ? hsrx_r :
		hit_lp ? lprx_r :
		hit_tm ? term_r :
		hit_m ? rd_m :
		hit_n ? rd_n : 8'h00;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DSRC_IDLE: if (setup) state_nxt = DSRC_ACCESS;
			DSRC_ACCESS: state_nxt = DSRC_IDLE;
			default: state_nxt = DSRC_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= DSRC_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_lo_r <= `DSRC_RST_SYNC_LO; // RULE3
			sync_hi_r <= `DSRC_RST_SYNC_HI;
		end else begin
			if (wr && hit_lo) sync_lo_r <= pwdata[7:0]; // RULE1
			if (wr && hit_hi) sync_hi_r <= pwdata[1:0]; // RULE11
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hsrx_r <= `DSRC_RST_LANE;
			lprx_r <= `DSRC_RST_LANE;
			term_r <= `DSRC_RST_LANE;
		end else begin
			if (wr && hit_hs) hsrx_r <= pwdata[7:0] & `DSRC_LANE_MASK; // RULE4
			if (wr && hit_lp) lprx_r <= pwdata[7:0] & `DSRC_LANE_MASK; // RULE5
			if (wr && hit_tm) term_r <= pwdata[7:0] & `DSRC_LANE_MASK; // RULE6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ov_r <= 1'b0;
			div_m_r <= `DSRC_RST_DIV_M;
			div_n_r <= `DSRC_RST_DIV_N;
			auto_m_r <= `DSRC_RST_DIV_M;
		end else begin
			auto_m_r <= auto_m; // RULE8
			if (wr && hit_m) begin
				div_ov_r <= pwdata[`DSRC_BIT_DIV_OV]; // RULE7
				div_m_r <= pwdata[4:0]; // RULE10
			end
			if (wr && hit_n) div_n_r <= pwdata[7:0]; // RULE12
		end
	end

	// outputs registered; software keeps the delay within range, larger values clamp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_fifo_depth <= {`DSRC_RST_SYNC_HI, `DSRC_RST_SYNC_LO};
			hs_rx_en <= 5'h00;
			lp_rx_en <= 5'h00;
			rx_term_en <= 5'h00;
			div_override <= 1'b0;
			div_setting <= '0;
		end else begin
			sync_fifo_depth <= ({sync_hi_r, sync_lo_r} > `DSRC_SYNC_MAX) ? `DSRC_SYNC_MAX
				: {sync_hi_r, sync_lo_r}; // RULE2
			hs_rx_en <= lane_sel(hsrx_r, lane_state_hs); // RULE13
			lp_rx_en <= lane_sel(lprx_r, lane_state_lp); // RULE13
			rx_term_en <= lane_sel(term_r, lane_state_term); // RULE13
			div_override <= div_ov_r; // RULE7
			div_setting.m <= div_ov_r ? div_m_r : auto_m_r; // RULE10
			div_setting.n <= div_ov_r ? div_n_r : auto_div_n; // RULE12
		end
	end

	sequence s_lo_write;
		wr && hit_lo;
	endsequence
	sequence s_depth_follow;
		##2 sync_fifo_depth[7:0] == $past(pwdata[7:0], 2);
	endsequence

	AST_SYNC_LO: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		s_lo_write |-> ##1 sync_lo_r == $past(pwdata[7:0])) else $error("sync low byte not stored");
	AST_DEPTH: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		(s_lo_write and (sync_hi_r == 2'h0)) |-> s_depth_follow) else $error("fifo depth not following delay");
	AST_DEPTH_MAX: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		sync_fifo_depth <= `DSRC_SYNC_MAX) else $error("fifo depth above maximum");
	AST_HS_OV: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		hsrx_r[`DSRC_BIT_OV] |=> hs_rx_en == {$past(hsrx_r[4]), $past(hsrx_r[3:0])}) else $error("hs override ignored");
	AST_LP_OV: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		lprx_r[`DSRC_BIT_OV] |=> lp_rx_en == {$past(lprx_r[4]), $past(lprx_r[3:0])}) else $error("lp override ignored");
	AST_TERM_OV: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		term_r[`DSRC_BIT_OV] |=> rx_term_en == {$past(term_r[4]), $past(term_r[3:0])}) else $error("term override ignored");
	AST_LANE_AUTO: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		$past(presetn) && !hsrx_r[`DSRC_BIT_OV] |=> hs_rx_en == $past(lane_state_hs)) else $error("hs lanes not from lane state");
	AST_DIV_OV: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		div_ov_r |=> div_setting.n == $past(div_n_r)) else $error("override n not applied");
	AST_M_OV: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		div_ov_r |=> div_setting.m == $past(div_m_r)) else $error("override m not applied");
	AST_M_READ: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		(setup && !pwrite && hit_m && !div_ov_r) |=> prdata[4:0] == $past(auto_m_r)) else $error("auto m not read");
	AST_AUTO_M: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		$past(presetn) |-> auto_m_r == $past(auto_m)) else $error("auto m not tracked");
	AST_HI: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		(wr && hit_hi) |=> sync_hi_r == $past(pwdata[1:0])) else $error("sync high bits not stored");
	AST_N_READ: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		(setup && !pwrite && hit_n && !div_ov_r) |=> prdata[7:0] == $past(auto_div_n)) else $error("auto n not read");

	// register bus checks: writes match setup edge, then one access edge with psel and penable high; reads match the setup edge only
	sequence s_write_to(sel);
		(setup && pwrite && sel) ##1 (psel && penable && pwrite && sel);
	endsequence

	sequence s_read_of(sel);
		setup && !pwrite && sel;
	endsequence

	property p_lp_auto;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && !lprx_r[`DSRC_BIT_OV] |=> lp_rx_en == $past(lane_state_lp);
	endproperty
	AST_LP_AUTO: assert property (p_lp_auto) // RULE13
		else $error("lp lanes not from lane state");

	property p_term_auto;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && !term_r[`DSRC_BIT_OV] |=> rx_term_en == $past(lane_state_term);
	endproperty
	AST_TERM_AUTO: assert property (p_term_auto) // RULE13
		else $error("term lanes not from lane state");

	property p_m_auto_set;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && !div_ov_r |=> div_setting.m == $past(auto_m_r);
	endproperty
	AST_M_AUTO_SET: assert property (p_m_auto_set) // RULE8
		else $error("auto m not applied");

	property p_n_auto_set;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && !div_ov_r |=> div_setting.n == $past(auto_div_n);
	endproperty
	AST_N_AUTO_SET: assert property (p_n_auto_set) // RULE12
		else $error("auto n not applied");

	property p_ov_out;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> div_override == $past(div_ov_r);
	endproperty
	AST_OV_OUT: assert property (p_ov_out) // RULE7
		else $error("override output not following register");

	property p_m_write;
		@(posedge pclk) disable iff (!presetn)
		s_write_to(hit_m) |=> div_ov_r == $past(pwdata[`DSRC_BIT_DIV_OV]) && div_m_r == $past(pwdata[4:0]);
	endproperty
	AST_M_WRITE: assert property (p_m_write) // RULE7
		else $error("divider m write lost");

	property p_n_write;
		@(posedge pclk) disable iff (!presetn)
		s_write_to(hit_n) |=> div_n_r == $past(pwdata[7:0]);
	endproperty
	AST_N_WRITE: assert property (p_n_write) // RULE12
		else $error("divider n write lost");

	property p_hs_write;
		@(posedge pclk) disable iff (!presetn)
		s_write_to(hit_hs) |=> hsrx_r == ($past(pwdata[7:0]) & `DSRC_LANE_MASK);
	endproperty
	AST_HS_WRITE: assert property (p_hs_write) // RULE4
		else $error("hs lane write lost");

	property p_lp_write;
		@(posedge pclk) disable iff (!presetn)
		s_write_to(hit_lp) |=> lprx_r == ($past(pwdata[7:0]) & `DSRC_LANE_MASK);
	endproperty
	AST_LP_WRITE: assert property (p_lp_write) // RULE5
		else $error("lp lane write lost");

	property p_tm_write;
		@(posedge pclk) disable iff (!presetn)
		s_write_to(hit_tm) |=> term_r == ($past(pwdata[7:0]) & `DSRC_LANE_MASK);
	endproperty
	AST_TM_WRITE: assert property (p_tm_write) // RULE6
		else $error("term lane write lost");

	property p_hs_read;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_hs) |=> prdata == {24'h000000, $past(hsrx_r)};
	endproperty
	AST_HS_READ: assert property (p_hs_read) // RULE4
		else $error("hs lane read wrong");

	property p_lp_read;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_lp) |=> prdata == {24'h000000, $past(lprx_r)};
	endproperty
	AST_LP_READ: assert property (p_lp_read) // RULE5
		else $error("lp lane read wrong");

	property p_tm_read;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_tm) |=> prdata == {24'h000000, $past(term_r)};
	endproperty
	AST_TM_READ: assert property (p_tm_read) // RULE6
		else $error("term lane read wrong");

	property p_lo_read;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_lo) |=> prdata == {24'h000000, $past(sync_lo_r)};
	endproperty
	AST_LO_READ: assert property (p_lo_read) // RULE1
		else $error("sync low byte read wrong");

	property p_hi_read;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_hi) |=> prdata == {30'h0, $past(sync_hi_r)};
	endproperty
	AST_HI_READ: assert property (p_hi_read) // RULE11
		else $error("sync high bits read wrong");

	property p_m_read_ov;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_m && div_ov_r) |=> prdata == {24'h000000, 1'b1, 2'h0, $past(div_m_r)};
	endproperty
	AST_M_READ_OV: assert property (p_m_read_ov) // RULE10
		else $error("stored m not read under override");

	property p_n_read_ov;
		@(posedge pclk) disable iff (!presetn)
		s_read_of(hit_n && div_ov_r) |=> prdata == {24'h000000, $past(div_n_r)};
	endproperty
	AST_N_READ_OV: assert property (p_n_read_ov) // RULE12
		else $error("stored n not read under override");

	property p_refused;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !mapped) |=>
			$stable({sync_hi_r, sync_lo_r, hsrx_r, lprx_r, term_r, div_ov_r, div_m_r, div_n_r});
	endproperty
	AST_REFUSED: assert property (p_refused) // RULE1
		else $error("unmapped access changed a register");

	property p_depth_full;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && ({sync_hi_r, sync_lo_r} <= `DSRC_SYNC_MAX) |=>
			sync_fifo_depth == $past({sync_hi_r, sync_lo_r});
	endproperty
	AST_DEPTH_FULL: assert property (p_depth_full) // RULE2
		else $error("fifo depth not following full delay");

	property p_depth_hold;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && $stable({sync_hi_r, sync_lo_r}) |=> $stable(sync_fifo_depth);
	endproperty
	AST_DEPTH_HOLD: assert property (p_depth_hold) // RULE2
		else $error("fifo depth moved without a delay write");
endmodule

// ===== dsrc_map.svh
`ifndef DSRC_MAP_SVH
`define DSRC_MAP_SVH
`define DSRC_IDX_SYNC_HI 8'h34
`define DSRC_IDX_SYNC_LO 8'h35
`define DSRC_IDX_HSRX 8'h36
`define DSRC_IDX_LPRX 8'h37
`define DSRC_IDX_TERM 8'h38
`define DSRC_IDX_DIV_M 8'h3A
`define DSRC_IDX_DIV_N 8'h3B
`define DSRC_RST_SYNC_LO 8'h20
`define DSRC_RST_SYNC_HI 2'h0
`define DSRC_RST_LANE 8'h00
`define DSRC_RST_DIV_M 5'h00
`define DSRC_RST_DIV_N 8'h00
`define DSRC_SYNC_MAX 10'h2FE
`define DSRC_BIT_OV 6
`define DSRC_BIT_CLK 4
`define DSRC_BIT_DIV_OV 7
`define DSRC_LANE_MASK 8'h5F
`endif

// ===== dsrc_pkg.sv
package dsrc_pkg;
	typedef struct packed {
		logic ovr;
		logic clk_lane;
		logic [3:0] data_lane;
	} dsrc_lane_t;
	typedef struct packed {
		logic [4:0] m;
		logic [7:0] n;
	} dsrc_div_t;
	typedef enum logic [1:0] {
		DSRC_IDLE,
		DSRC_ACCESS
	} dsrc_state_t;
endpackage

// ===== dsrc_host_model.sv
`timescale 1ns/1ps
// far-side stand-in: lane count, dual mode, N and hs lane state set by cfg; bytes per pixel, lp and term state fixed
module dsrc_host_model (
	input wire logic pclk,
	input wire logic [1:0] cfg,
	output logic [2:0] lane_count,
	output logic [1:0] bytes_per_pixel,
	output logic dual_mode,
	output logic [7:0] auto_div_n,
	output logic [4:0] lane_state_hs,
	output logic [4:0] lane_state_lp,
	output logic [4:0] lane_state_term
);
	always_ff @(posedge pclk) begin
		lane_count <= {1'b0, cfg} + 3'h1;
		bytes_per_pixel <= 2'h2;
		dual_mode <= cfg[0];
		auto_div_n <= {6'h00, cfg} + 8'h10;
		lane_state_hs <= 5'h0A ^ {3'h0, cfg};
		lane_state_lp <= 5'h15;
		lane_state_term <= 5'h1E;
	end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	import dsrc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, dual_mode, div_override;
	logic [1:0] cfg = 2'h0, bytes_per_pixel;
	logic [2:0] lane_count;
	logic [7:0] auto_div_n;
	logic [4:0] st_hs, st_lp, st_term, hs, lp, term;
	logic [9:0] depth;
	dsrc_div_t div_setting;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	dsrc_host_model host (.pclk(pclk), .cfg(cfg), .lane_count(lane_count), .bytes_per_pixel(bytes_per_pixel),
		.dual_mode(dual_mode), .auto_div_n(auto_div_n), .lane_state_hs(st_hs), .lane_state_lp(st_lp),
		.lane_state_term(st_term));
	dsrc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lane_count(lane_count), .bytes_per_pixel(bytes_per_pixel), .dual_mode(dual_mode),
		.auto_div_n(auto_div_n), .lane_state_hs(st_hs), .lane_state_lp(st_lp), .lane_state_term(st_term),
		.sync_fifo_depth(depth), .hs_rx_en(hs), .lp_rx_en(lp), .rx_term_en(term),
		.div_override(div_override), .div_setting(div_setting));
	wire [14:0] lanes_o = {hs, lp, term};
	wire [14:0] lanes_s = {st_hs, st_lp, st_term};
	initial begin
		forever #50 pclk = ~pclk;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			$display("mismatch timeout expected finish seen %0d cycles", cyc);
			error_cnt++;
			final_report();
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	task automatic xfer(logic w, logic [7:0] idx, logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(string nm, logic [7:0] idx, logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(nm, {24'h000000, exp}, rd);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("depth", 32'h020, {22'h0, depth});
		rchk("sync_lo", 8'h35, 8'h20);
		xfer(1'b1, 8'h34, 8'h02);
		xfer(1'b1, 8'h35, 8'hFE);
		repeat (3) @(posedge pclk);
		chk("depth", 32'h2FE, {22'h0, depth});
		rchk("sync_hi", 8'h34, 8'h02);
		rchk("sync_lo", 8'h35, 8'hFE);
		xfer(1'b1, 8'h34, 8'h00);
		xfer(1'b1, 8'h35, 8'h40);
		repeat (3) @(posedge pclk);
		chk("depth", 32'h040, {22'h0, depth});
		rchk("sync_hi", 8'h34, 8'h00);
		xfer(1'b0, 8'h39, 8'h00);
		chk("unmapped", 32'h1, {31'h0, err});
		$display("test sync done");
		cfg <= 2'h3;
		for (int i = 0; i < 3; i++) begin
			rchk("lane_rst", 8'h36 + 8'(i), 8'h00);
			xfer(1'b1, 8'h36 + 8'(i), 8'hFF);
			rchk("lane_rd", 8'h36 + 8'(i), 8'h5F);
			chk("lane_ov", 32'h1F, {27'h0, lanes_o[14-5*i -: 5]});
			xfer(1'b1, 8'h36 + 8'(i), 8'h55);
			repeat (3) @(posedge pclk);
			chk("lane_ov", 32'h15, {27'h0, lanes_o[14-5*i -: 5]});
			xfer(1'b1, 8'h36 + 8'(i), 8'h15);
			repeat (3) @(posedge pclk);
			chk("lane_int", {27'h0, lanes_s[14-5*i -: 5]}, {27'h0, lanes_o[14-5*i -: 5]});
		end
		$display("test lanes done");
		rchk("auto_m", 8'h3A, 8'h18);
		rchk("auto_n", 8'h3B, 8'h13);
		cfg <= 2'h0;
		repeat (4) @(posedge pclk);
		rchk("auto_m", 8'h3A, 8'h03);
		chk("div_ov", 32'h0, {31'h0, div_override});
		chk("div_auto", {19'h0, 5'h03, 8'h10}, {19'h0, div_setting});
		xfer(1'b1, 8'h3A, 8'h93);
		xfer(1'b1, 8'h3B, 8'h55);
		repeat (3) @(posedge pclk);
		rchk("ov_m", 8'h3A, 8'h93);
		rchk("ov_n", 8'h3B, 8'h55);
		chk("div_ov", 32'h1, {31'h0, div_override});
		chk("div_set", {19'h0, 5'h13, 8'h55}, {19'h0, div_setting});
		$display("test divider done");
		final_report();
	end
endmodule
